// *** verilog/mmc_consts.vh ***
// Constants for the memory map configuration register bank.
// Assumes a byte-addressed APB with 32-bit data, one register per word.
`ifndef MMC_CONSTS_VH
`define MMC_CONSTS_VH

// Register byte offsets
`define MMC_OFS_INPUT_GATING   12'h000
`define MMC_OFS_ACCESS_MAP     12'h004
`define MMC_OFS_SIZE_ID        12'h008
`define MMC_OFS_SECONDARY_ID   12'h00C
`define MMC_OFS_BUS_STATUS     12'h010

// Input gating register fields
`define MMC_GATE_ADDR          0
`define MMC_GATE_CTRL0         2
`define MMC_GATE_CTRL1         3
`define MMC_GATE_CTRL2         4
`define MMC_GATE_ALE           5
`define MMC_GATE_WRH           6
`define MMC_GATE_WMASK         8'h7D
`define MMC_GATE_RESET         8'h00

// Access map register fields
`define MMC_MAP_SRAM_FETCH     0
`define MMC_MAP_SEC_FETCH      1
`define MMC_MAP_PRI_FETCH      2
`define MMC_MAP_SEC_READ       3
`define MMC_MAP_PRI_READ       4
`define MMC_MAP_UNUSED         5
`define MMC_MAP_PERIPH         7
`define MMC_MAP_WMASK          8'h9F
`define MMC_MAP_CFG_LSB        1
`define MMC_MAP_CFG_MSB        4

// Identification field positions
`define MMC_ID0_FLASH_LSB      0
`define MMC_ID0_SRAM_LSB       4
`define MMC_ID1_SIZE_LSB       0
`define MMC_ID1_TYPE_LSB       4

// Memory regions of the 24-bit byte address space
`define MMC_ADDR_W             24
`define MMC_PRI_BASE           6'h00
`define MMC_PRI_TAG_LSB        18
`define MMC_PRI_SECT_LSB       15
`define MMC_SEC_BASE           10'h100
`define MMC_SEC_TAG_LSB        14
`define MMC_SEC_SECT_LSB       12
`define MMC_SRAM_BASE          12'h200
`define MMC_SRAM_TAG_LSB       12

`endif

// *** verilog/mmc_sector_decode.v ***
// Sector select decode for primary flash, secondary flash and SRAM.
// Assumes strobes and address are synchronous to SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.vh"

module mmc_sector_decode #(
  parameter PRI_SECTORS = 8,
  parameter SEC_SECTORS = 4
) (
  input  wire                      clk,
  input  wire                      srst,
  input  wire                      clk_en,
  input  wire [`MMC_ADDR_W-1:0]    addr,
  input  wire                      sep_mode,
  input  wire                      fetch_strobe,
  input  wire                      read_strobe,
  input  wire [7:0]                access_map,
  output reg  [PRI_SECTORS-1:0]    primary_sector_selects,
  output reg  [SEC_SECTORS-1:0]    secondary_sector_select,
  output reg                       sram_select
);

  wire [2:0] pri_idx;
  wire [1:0] sec_idx;
  wire       pri_hit;
  wire       sec_hit;
  wire       sram_hit;
  reg        pri_ok;
  reg        sec_ok;
  reg        sram_ok;
  reg  [PRI_SECTORS-1:0] next_pri;
  reg  [SEC_SECTORS-1:0] next_sec;

  assign pri_idx  = addr[`MMC_PRI_TAG_LSB-1:`MMC_PRI_SECT_LSB];
  assign sec_idx  = addr[`MMC_SEC_TAG_LSB-1:`MMC_SEC_SECT_LSB];
  assign pri_hit  = addr[`MMC_ADDR_W-1:`MMC_PRI_TAG_LSB] == `MMC_PRI_BASE;
  assign sec_hit  = addr[`MMC_ADDR_W-1:`MMC_SEC_TAG_LSB] ==
                    `MMC_SEC_BASE;
  assign sram_hit = addr[`MMC_ADDR_W-1:`MMC_SRAM_TAG_LSB] ==
                    `MMC_SRAM_BASE;

  // Map bits only count in separate program/data mode
  always @* begin
    if (sep_mode) begin
      sram_ok = read_strobe |
                (fetch_strobe & access_map[`MMC_MAP_SRAM_FETCH]);
      sec_ok  = (fetch_strobe & access_map[`MMC_MAP_SEC_FETCH]) |
                (read_strobe & access_map[`MMC_MAP_SEC_READ]);
      pri_ok  = (fetch_strobe & access_map[`MMC_MAP_PRI_FETCH]) |
                (read_strobe & access_map[`MMC_MAP_PRI_READ]);
    end else begin
      sram_ok = 1'b1;
      sec_ok  = 1'b1;
      pri_ok  = 1'b1;
    end
  end

  // One select per sector
  genvar i;
  generate
    for (i = 0; i < PRI_SECTORS; i = i + 1) begin : g_pri
      always @* begin
        next_pri[i] = pri_hit & pri_ok & (pri_idx == i);
      end
    end
    for (i = 0; i < SEC_SECTORS; i = i + 1) begin : g_sec
      always @* begin
        next_sec[i] = sec_hit & sec_ok & (sec_idx == i);
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      primary_sector_selects  <= {PRI_SECTORS{1'b0}};
      secondary_sector_select <= {SEC_SECTORS{1'b0}};
      sram_select             <= 1'b0;
    end else if (clk_en) begin
      primary_sector_selects  <= next_pri;
      secondary_sector_select <= next_sec;
      sram_select             <= sram_hit & sram_ok;
    end
  end

endmodule // mmc_sector_decode

`default_nettype wire

// *** verilog/mmc_config_regs.v ***
// Configuration and identification register bank with APB slave,
// input gating toward the decode logic array and sector decode.
// Assumes all pins synchronous to SYS_CLK and an APB master on SYS_CLK.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.vh"

// Contract
// - Each control input gate bit at 1 disconnects that input, 0 connects.
// - Address latch strobe gate at 1 cuts the strobe, 0 passes it.
// - High-byte write gate at 1 removes that strobe, 0 keeps it.
// - Separate mode takes A3-A0 from port F low, A7-A4 from bus upper.
// - Reset loads map bits 1-4 from config, clears bits 0 and 7.
// - Map bits 0-4 act only in separate program/data mode.
// - Map bit 0 lets program fetch reach SRAM.
// - Secondary memory: fetch needs bit 1, read needs bit 3.
// - Primary flash: fetch needs bit 2, read needs bit 4.
// - Map bit 7 enables port F peripheral mode; bit 5 unused, zero.
// - Size ID low nibble gives primary flash size code.
// - Size ID high nibble gives SRAM size code.
// - Secondary ID bits 3-0 give secondary memory size code.
// - Secondary ID bits 5-4 give type; bits 7-6 read zero.
// - Decode gives eight primary, four secondary, one SRAM select.
// - Address gate bit at 1 blocks low address byte, 0 connects.
// - Control gates at bits 4,3,2; strobe bit 5; high-byte write bit 6.
module mmc_config_regs #(
  parameter [3:0] PRIMARY_SIZE_CODE   = 4'h5,
  parameter [3:0] SRAM_SIZE_CODE      = 4'h3,
  parameter [3:0] SECONDARY_SIZE_CODE = 4'h2,
  parameter [1:0] SECONDARY_TYPE_CODE = 2'h0,
  parameter       PRI_SECTORS         = 8,
  parameter       SEC_SECTORS         = 4
) (
  input  wire                    SYS_CLK,
  input  wire                    SRST,
  input  wire                    CLK_EN,
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [11:0]             PADDR,
  input  wire [31:0]             PWDATA,
  output reg  [31:0]             PRDATA,
  output wire                    PREADY,
  output wire                    PSLVERR,
  input  wire [3:0]              CFG_MAP_DEFAULT,
  input  wire                    CFG_SEP_MODE,
  input  wire [2:0]              BUS_CTRL_IN,
  input  wire                    ADDR_LATCH_STROBE,
  input  wire                    HIGH_BYTE_WRITE_STROBE,
  input  wire                    PROGRAM_FETCH_STROBE,
  input  wire                    READ_STROBE,
  input  wire [`MMC_ADDR_W-1:0]  BUS_ADDR,
  input  wire [3:0]              PORT_F_LOW_PINS,
  input  wire [7:4]              MUX_BUS_UPPER_LINES,
  output reg  [2:0]              DLA_BUS_CTRL,
  output reg                     DLA_ADDR_LATCH_STROBE,
  output reg                     DLA_HIGH_BYTE_WRITE,
  output reg  [7:0]              DLA_ADDR_LOW,
  output wire                    PORT_F_PERIPH_EN,
  output wire [PRI_SECTORS-1:0]  PRIMARY_SECTOR_SELECTS,
  output wire [SEC_SECTORS-1:0]  SECONDARY_SECTOR_SELECT,
  output wire                    SRAM_SELECT
);

  reg  [7:0]             pld_input_gating;
  reg  [7:0]             code_data_access_map;
  reg                    bad_addr;
  reg  [31:0]            next_rdata;
  reg                    next_bad;
  reg  [7:0]             next_addr_low;
  reg  [2:0]             next_ctrl;
  wire [7:0]             memory_size_id;
  wire [7:0]             secondary_memory_id;
  wire [7:0]             bus_status;
  wire [`MMC_ADDR_W-1:0] decode_addr;
  wire                   setup_phase;
  wire                   access_done;
  wire                   wr_done;

  // Identification values are fixed by build parameters
  assign memory_size_id = {SRAM_SIZE_CODE, PRIMARY_SIZE_CODE};
  assign secondary_memory_id = {2'b00, SECONDARY_TYPE_CODE,
                                SECONDARY_SIZE_CODE};
  assign bus_status = {7'h00, CFG_SEP_MODE};

  // APB handshake: no wait states while CLK_EN is high; read data comes from a flop loaded in the setup cycle
  assign setup_phase = PSEL & ~PENABLE & CLK_EN;
  assign PREADY      = PSEL & PENABLE & CLK_EN;
  assign access_done = PREADY;
  assign wr_done     = access_done & PWRITE & ~bad_addr;
  assign PSLVERR     = access_done & bad_addr;

  // Read mux and address check, captured in the setup cycle
  always @* begin
    next_rdata = 32'h0000_0000;
    next_bad   = 1'b0;
    if (PADDR == `MMC_OFS_INPUT_GATING) begin
      next_rdata[7:0] = pld_input_gating;
    end else if (PADDR == `MMC_OFS_ACCESS_MAP) begin
      next_rdata[7:0] = code_data_access_map;
    end else if (PADDR == `MMC_OFS_SIZE_ID) begin
      next_rdata[7:0] = memory_size_id;
    end else if (PADDR == `MMC_OFS_SECONDARY_ID) begin
      next_rdata[7:0] = secondary_memory_id;
    end else if (PADDR == `MMC_OFS_BUS_STATUS) begin
      next_rdata[7:0] = bus_status;
    end else begin
      next_bad = 1'b1;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      PRDATA   <= 32'h0000_0000;
      bad_addr <= 1'b0;
    end else if (setup_phase) begin
      PRDATA   <= PWRITE ? 32'h0000_0000 : next_rdata;
      bad_addr <= next_bad;
    end
  end

  // Writable registers; ID and status offsets ignore writes
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      pld_input_gating <= `MMC_GATE_RESET;
      code_data_access_map <= 8'h00;
      code_data_access_map[`MMC_MAP_CFG_MSB:`MMC_MAP_CFG_LSB] <=
        CFG_MAP_DEFAULT;
    end else if (wr_done) begin
      if (PADDR == `MMC_OFS_INPUT_GATING) begin
        pld_input_gating <= PWDATA[7:0] & `MMC_GATE_WMASK;
      end else if (PADDR == `MMC_OFS_ACCESS_MAP) begin
        // Unused bits are forced to zero so reads stay clean
        code_data_access_map <= PWDATA[7:0] & `MMC_MAP_WMASK;
      end
    end
  end

  assign PORT_F_PERIPH_EN = code_data_access_map[`MMC_MAP_PERIPH];

  // Address byte source depends on the bus mode
  always @* begin
    if (CFG_SEP_MODE) begin
      next_addr_low = {MUX_BUS_UPPER_LINES, PORT_F_LOW_PINS};
    end else begin
      next_addr_low = BUS_ADDR[7:0];
    end
  end

  // Per control input gate
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ctrl
      always @* begin
        next_ctrl[c] = BUS_CTRL_IN[c] &
                       ~pld_input_gating[`MMC_GATE_CTRL0 + c];
      end
    end
  endgenerate

  // Gated inputs toward the decode array; a blocked input holds low,
  // which stops toggling and so saves power downstream
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      DLA_BUS_CTRL          <= 3'b000;
      DLA_ADDR_LATCH_STROBE <= 1'b0;
      DLA_HIGH_BYTE_WRITE   <= 1'b0;
      DLA_ADDR_LOW          <= 8'h00;
    end else if (CLK_EN) begin
      DLA_BUS_CTRL          <= next_ctrl;
      DLA_ADDR_LATCH_STROBE <= ADDR_LATCH_STROBE &
                               ~pld_input_gating[`MMC_GATE_ALE];
      DLA_HIGH_BYTE_WRITE   <= HIGH_BYTE_WRITE_STROBE &
                               ~pld_input_gating[`MMC_GATE_WRH];
      DLA_ADDR_LOW          <= pld_input_gating[`MMC_GATE_ADDR] ?
                               8'h00 : next_addr_low;
    end
  end

  // Sector decode sees the gated low byte, so blocked address bits
  // read as zero; the sector fields sit above bit 11 and are unaffected
  assign decode_addr = {BUS_ADDR[`MMC_ADDR_W-1:8],
                        pld_input_gating[`MMC_GATE_ADDR] ?
                        8'h00 : next_addr_low};

  mmc_sector_decode #(
    .PRI_SECTORS (PRI_SECTORS),
    .SEC_SECTORS (SEC_SECTORS)
  ) u_decode (
    .clk                     (SYS_CLK),
    .srst                    (SRST),
    .clk_en                  (CLK_EN),
    .addr                    (decode_addr),
    .sep_mode                (CFG_SEP_MODE),
    .fetch_strobe            (PROGRAM_FETCH_STROBE),
    .read_strobe             (READ_STROBE),
    .access_map              (code_data_access_map),
    .primary_sector_selects  (PRIMARY_SECTOR_SELECTS),
    .secondary_sector_select (SECONDARY_SECTOR_SELECT),
    .sram_select             (SRAM_SELECT)
  );

endmodule // mmc_config_regs

`default_nettype wire

// *** sim/mmc_chk.sv ***
// Port checker for the configuration register bank.
// Assumes one clock SYS_CLK and synchronous active-high SRST.
`timescale 1ns/10ps
`default_nettype none
module mmc_chk #(
  parameter PRI_SECTORS = 8,
  parameter SEC_SECTORS = 4
) (
  input wire logic                   SYS_CLK,
  input wire logic                   SRST,
  input wire logic                   CLK_EN,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic [11:0]            PADDR,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic [2:0]             BUS_CTRL_IN,
  input wire logic                   ADDR_LATCH_STROBE,
  input wire logic                   HIGH_BYTE_WRITE_STROBE,
  input wire logic                   READ_STROBE,
  input wire logic                   CFG_SEP_MODE,
  input wire logic [23:0]            BUS_ADDR,
  input wire logic [2:0]             DLA_BUS_CTRL,
  input wire logic                   DLA_ADDR_LATCH_STROBE,
  input wire logic                   DLA_HIGH_BYTE_WRITE,
  input wire logic                   PORT_F_PERIPH_EN,
  input wire logic [PRI_SECTORS-1:0] PRIMARY_SECTOR_SELECTS,
  input wire logic [SEC_SECTORS-1:0] SECONDARY_SECTOR_SELECT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence s_setup;
    PSEL && !PENABLE && CLK_EN;
  endsequence
  sequence s_access;
    PSEL && PENABLE && CLK_EN;
  endsequence
  a_ready_access: assert property (
    PREADY == (PSEL && PENABLE && CLK_EN)) else $error("ready mismatch");
  a_id_top_zero: assert property (
    (s_setup and PADDR == 12'h00C) ##1 s_access |-> PRDATA[7:6] == 2'b00)
    else $error("id top bits set");
  a_err_unmapped: assert property (
    PREADY && PADDR > 12'h010 |-> PSLVERR) else $error("no error flag");
  a_ctrl_gated: assert property (
    $past(CLK_EN) |-> (DLA_BUS_CTRL & ~$past(BUS_CTRL_IN)) == 3'b000)
    else $error("control input leaked");
  a_ale_gated: assert property (
    $past(CLK_EN) && DLA_ADDR_LATCH_STROBE |-> $past(ADDR_LATCH_STROBE))
    else $error("latch strobe leaked");
  a_wrh_gated: assert property (
    $past(CLK_EN) && DLA_HIGH_BYTE_WRITE |-> $past(HIGH_BYTE_WRITE_STROBE))
    else $error("high byte strobe leaked");
  a_sel_onehot: assert property (
    $onehot0(PRIMARY_SECTOR_SELECTS) && $onehot0(SECONDARY_SECTOR_SELECT))
    else $error("several sector selects");
  a_pri_sector: assert property (
    CLK_EN && READ_STROBE && !CFG_SEP_MODE && BUS_ADDR[23:18] == 6'h00
    |=> PRIMARY_SECTOR_SELECTS == (1 << $past(BUS_ADDR[17:15])))
    else $error("wrong primary sector");
  a_periph_reset: assert property (
    $fell(SRST) |-> !PORT_F_PERIPH_EN) else $error("periph set at reset");
endmodule // mmc_chk
bind mmc_config_regs mmc_chk #(.PRI_SECTORS(PRI_SECTORS),
  .SEC_SECTORS(SEC_SECTORS)) u_chk (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BUS_CTRL_IN(BUS_CTRL_IN), .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
  .HIGH_BYTE_WRITE_STROBE(HIGH_BYTE_WRITE_STROBE), .BUS_ADDR(BUS_ADDR),
  .READ_STROBE(READ_STROBE), .CFG_SEP_MODE(CFG_SEP_MODE),
  .DLA_BUS_CTRL(DLA_BUS_CTRL), .DLA_ADDR_LATCH_STROBE(DLA_ADDR_LATCH_STROBE),
  .DLA_HIGH_BYTE_WRITE(DLA_HIGH_BYTE_WRITE),
  .PORT_F_PERIPH_EN(PORT_F_PERIPH_EN),
  .PRIMARY_SECTOR_SELECTS(PRIMARY_SECTOR_SELECTS),
  .SECONDARY_SECTOR_SELECT(SECONDARY_SECTOR_SELECT));
`default_nettype wire

// *** sim/mmc_mcu_model.sv ***
// Processor bus model: one strobe cycle per call of xfer.
// Assumes the bench calls xfer off or on a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module mmc_mcu_model (
  input  wire logic  clk,
  output logic [23:0] bus_addr,
  output logic [3:0]  pf_low,
  output logic [7:4]  mux_up,
  output logic [2:0]  ctrl,
  output logic        ale,
  output logic        wrh,
  output logic        fetch,
  output logic        rd
);
  initial {bus_addr, mux_up, pf_low, ctrl, ale, wrh, fetch, rd} = '0;
  task xfer(input logic f, input logic r, input logic [23:0] a,
            input logic [7:0] p, input logic [4:0] c);
    @(posedge clk);
    fetch <= f;
    rd <= r;
    bus_addr <= a;
    {mux_up, pf_low} <= p;
    {wrh, ale, ctrl} <= c;
    @(posedge clk);
    {fetch, rd, wrh, ale, ctrl} <= '0;
    // Released lines show the inverse so stale values never look valid
    bus_addr <= ~a;
    {mux_up, pf_low} <= ~p;
  endtask
endmodule // mmc_mcu_model
`default_nettype wire

// *** sim/test_mmc_config_regs.sv ***
// Self-checking bench for the configuration register bank.
// Assumes the checker is bound and the bus model stands beside uut.
`timescale 1ns/10ps
`default_nettype none
module test_mmc_config_regs;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sep = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0]  cfg = 4'hA, pfl, sec;
  logic [7:4]  mux;
  logic [7:0]  pri, dlow, g;
  logic [23:0] ba;
  logic [2:0]  ctl, dctl;
  logic        pready, pslverr, e, periph, sram, dale, dwrh, ale, wrh;
  logic        fet, rds, ok;
  int bad_count = 0, tests_run = 0;
  logic [7:0]  gt [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h01,
                          8'h7D};
  logic [23:0] na [4] = '{24'h008000, 24'h038000, 24'h403000, 24'h200000};
  logic [12:0] nx [4] = '{13'h0040, 13'h1000, 13'h0010, 13'h0001};
  logic [23:0] ra [3] = '{24'h200000, 24'h400000, 24'h000000};
  int rg [6] = '{0, 1, 2, 1, 2, 0};
  int sh [3] = '{0, 1, 5};
  always #5 sys_clk = ~sys_clk;
  mmc_mcu_model mcu (.clk(sys_clk), .bus_addr(ba), .pf_low(pfl), .mux_up(mux),
    .ctrl(ctl), .ale(ale), .wrh(wrh), .fetch(fet), .rd(rds));
  mmc_config_regs #(.PRIMARY_SIZE_CODE(4'h6), .SRAM_SIZE_CODE(4'h5),
    .SECONDARY_SIZE_CODE(4'h3), .SECONDARY_TYPE_CODE(2'h1)) uut (
    .SYS_CLK(sys_clk), .SRST(srst), .CLK_EN(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CFG_MAP_DEFAULT(cfg), .CFG_SEP_MODE(sep), .BUS_CTRL_IN(ctl),
    .ADDR_LATCH_STROBE(ale), .HIGH_BYTE_WRITE_STROBE(wrh),
    .PROGRAM_FETCH_STROBE(fet), .READ_STROBE(rds), .BUS_ADDR(ba),
    .PORT_F_LOW_PINS(pfl), .MUX_BUS_UPPER_LINES(mux), .DLA_BUS_CTRL(dctl),
    .DLA_ADDR_LATCH_STROBE(dale), .DLA_HIGH_BYTE_WRITE(dwrh),
    .DLA_ADDR_LOW(dlow), .PORT_F_PERIPH_EN(periph),
    .PRIMARY_SECTOR_SELECTS(pri), .SECONDARY_SECTOR_SELECT(sec),
    .SRAM_SELECT(sram));
  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    tests_run++;
    if (y !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, y);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 50) bad_count++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task sel(input logic [12:0] x);
    #1 chk("selects", x, {pri, sec, sram});
  endtask
  initial begin
    #200000 bad_count++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 0;
    apb(0, 12'h004, 0); chk("map", {27'h0, cfg, 1'b0}, q);
    chk("periph", 0, periph);
    for (int i = 0; i < 2; i++) begin
      apb(0, 12'h008, 0); chk("size id", 8'h56, q);
      apb(0, 12'h00C, 0); chk("second id", 8'h13, q);
      apb(1, 12'h008, 32'hFFFF_FFFF);
      apb(1, 12'h00C, 32'hFFFF_FFFF);
    end
    apb(0, 12'h020, 0); chk("error", 1, e);
    foreach (gt[i]) begin
      g = gt[i];
      apb(1, 12'h000, {24'h0, g});
      mcu.xfer(0, 0, 24'h0000A5, 8'h00, 5'h1F);
      #1 chk("gated", {~g[6], ~g[5], ~g[4:2], g[0] ? 8'h00 : 8'hA5},
             {dwrh, dale, dctl, dlow});
    end
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0); chk("gating", 8'h7D, q);
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'hFFFF_FFFF);
    apb(0, 12'h004, 0); chk("map", 8'h9F, q);
    chk("periph", 1, periph);
    apb(1, 12'h004, 0);
    #1 chk("periph", 0, periph);
    foreach (na[k]) begin
      mcu.xfer(k[0], !k[0], na[k], 8'h00, 0);
      sel(nx[k]);
    end
    @(posedge sys_clk) sep <= 1;
    mcu.xfer(0, 0, 24'h000000, 8'h3C, 0);
    #1 chk("low byte", 8'h3C, dlow);
    apb(0, 12'h010, 0); chk("status", 1, q);
    for (int m = 0; m < 32; m++) begin
      apb(1, 12'h004, m);
      for (int s = 0; s < 6; s++) begin
        ok = (s == 5) ? 1'b1 : m[s];
        mcu.xfer(s < 3, s >= 3, ra[rg[s]], 8'h00, 0);
        sel(13'(ok) << sh[rg[s]]);
      end
    end
    apb(1, 12'h004, 32'h0000_0081);
    @(posedge sys_clk) {sep, cfg, srst} <= {1'b0, 4'h5, 1'b1};
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    apb(0, 12'h004, 0); chk("map", 8'h0A, q);
    chk("periph", 0, periph);
    close_out;
  end
endmodule // test_mmc_config_regs
`default_nettype wire
